// [src/ddrmr_burst.sv]
`timescale 1ns/10ps
`default_nettype none
module ddrmr_burst
  import ddrmr_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Burst setup
  input  wire logic [2:0] burst_len,
  input  wire logic       interleave,
  // Column step
  input  wire logic       step,
  input  wire logic [2:0] start,
  input  wire logic [2:0] idx,
  output logic      [2:0] col_o,
  output logic            col_vld_o
);

  logic [2:0] col_r, col_nxt;
  logic       vld_r, vld_nxt;
  logic [2:0] mask;

  // ==========================================================
  // Column order
  always_comb
  begin
    case (burst_len)
      BL_CODE_2: mask = MASK_2;
      BL_CODE_4: mask = MASK_4;
      BL_CODE_8: mask = MASK_8;
      default:   mask = MASK_8;
    endcase
    vld_nxt = step;
    col_nxt = col_r;
    if (step)
    begin
      if (interleave)
        col_nxt = ((start ^ idx) & mask) | (start & ~mask);
      else
        col_nxt = (3'(start + idx) & mask) | (start & ~mask);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      col_r <= 3'h0;
      vld_r <= 1'b0;
    end
    else
    begin
      col_r <= col_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign col_o     = col_r;
  assign col_vld_o = vld_r;

  // ==========================================================
  // Checks
  a_burst_seq8: assert property (@(posedge mclk) disable iff (!rstn)
    step && !interleave && burst_len == BL_CODE_8 |=> col_r == $past(3'(start + idx)))
    else $error("sequential burst column wrong");
  a_burst_int4: assert property (@(posedge mclk) disable iff (!rstn)
    step && interleave && burst_len == BL_CODE_4
    |=> col_r == ((($past(start) ^ $past(idx)) & MASK_4) | ($past(start) & ~MASK_4)))
    else $error("interleaved burst column wrong");
  c_burst_int: cover property (@(posedge mclk) disable iff (!rstn) step && interleave);

endmodule : ddrmr_burst
`default_nettype wire

// [src/ddrmr_pkg.sv]
// Behaviour
// - Mode write needs all-idle banks, CKE high.
// - Capture address A0..A12 on mode write.
// - Rewrite allowed in operation when banks idle.
// - Fields: burst length, ordering, CAS latency.
// - Bit 7 selects test mode, normally low.
// - Bit 8 high requests DLL reset.
// - Burst order: wrap sequential or XOR interleave.
`default_nettype none
package ddrmr_pkg;

  // ==========================================================
  // Field layout and reset values
  localparam int          ADDR_W        = 13;
  localparam int          BL_LSB        = 0;
  localparam int          AM_BIT        = 3;
  localparam int          CL_LSB        = 4;
  localparam int          TM_BIT        = 7;
  localparam int          DR_BIT        = 8;
  localparam int          EM_DLL_BIT    = 0;
  localparam int          AP_BIT        = 10;
  localparam logic [12:0] MODE_RST      = 13'h0000;
  localparam logic [2:0]  BL_CODE_2     = 3'h1;
  localparam logic [2:0]  BL_CODE_4     = 3'h2;
  localparam logic [2:0]  BL_CODE_8     = 3'h3;
  localparam logic [2:0]  MASK_2        = 3'h1;
  localparam logic [2:0]  MASK_4        = 3'h3;
  localparam logic [2:0]  MASK_8        = 3'h7;

  // ==========================================================
  // Timing counts in CK cycles, and minimum refresh command count
  localparam logic [1:0]  MRS_CK_CYC    = 2'h2;
  localparam logic [7:0]  DLL_LOCK_CYC  = 8'hC8;
  localparam logic [1:0]  MIN_REFRESH   = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] a;
  } ddrmr_pins_t;

  typedef struct packed {
    logic [3:0] vendor;
    logic       dll_reset;
    logic       test_mode;
    logic [2:0] cas_lat;
    logic       interleave;
    logic [2:0] burst_len;
  } ddrmr_mode_t;

  typedef enum {
    ST_POWER, ST_PRE1, ST_EMRS, ST_MID, ST_REFRESH, ST_READY
  } ddrmr_init_t;

endpackage : ddrmr_pkg
`default_nettype wire

// [src/ddrmr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ddrmr_top
  import ddrmr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Memory pins
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  ba,
  input  wire logic [12:0] a,
  // Mode state
  output ddrmr_mode_t      mode_o,
  output logic             dll_en_o,
  output logic             dll_locked_o,
  output logic             read_ok_o,
  output logic             mrs_busy_o,
  output logic             init_done_o,
  output logic             cmd_reject_o,
  // Burst column order
  input  wire logic        burst_step,
  input  wire logic [2:0]  burst_start,
  input  wire logic [2:0]  burst_idx,
  output logic      [2:0]  burst_col_o,
  output logic             burst_col_vld_o
);

  // ==========================================================
  // Pin synchronisers
  ddrmr_pins_t pins_s1, pins_s2, pins_s3;
  logic        ck_s1, ck_s2, ck_s3, ck_lvl_r, ck_lvl_nxt;
  logic        ck_rise;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pins_s1  <= '0;
      pins_s2  <= '0;
      pins_s3  <= '0;
      ck_s1    <= 1'b0;
      ck_s2    <= 1'b0;
      ck_s3    <= 1'b0;
      ck_lvl_r <= 1'b0;
    end
    else
    begin
      pins_s1  <= '{cke, cs_n, ras_n, cas_n, we_n, ba, a};
      pins_s2  <= pins_s1;
      pins_s3  <= pins_s2;
      ck_s1    <= ck;
      ck_s2    <= ck_s1;
      ck_s3    <= ck_s2;
      ck_lvl_r <= ck_lvl_nxt;
    end
  end

  // CK level changes only once two stages agree
  always_comb
  begin
    ck_lvl_nxt = (ck_s2 == ck_s3) ? ck_s3 : ck_lvl_r;
    ck_rise    = (ck_s2 == ck_s3) && ck_s3 && !ck_lvl_r;
  end

  // ==========================================================
  // Command decode
  function automatic logic is_cmd(ddrmr_pins_t p, logic ras, logic cas, logic we);
    is_cmd = p.cke && !p.cs_n && p.ras_n == ras && p.cas_n == cas && p.we_n == we;
  endfunction : is_cmd

  logic cmd_mrs, cmd_emrs, cmd_pre, cmd_pre_all, cmd_ref, cmd_act;
  logic banks_idle, mrs_acc, emrs_acc;

  always_comb
  begin
    cmd_mrs     = ck_rise && is_cmd(pins_s3, 1'b0, 1'b0, 1'b0) && !pins_s3.ba[0];
    cmd_emrs    = ck_rise && is_cmd(pins_s3, 1'b0, 1'b0, 1'b0) && pins_s3.ba[0];
    cmd_pre     = ck_rise && is_cmd(pins_s3, 1'b0, 1'b1, 1'b0);
    cmd_pre_all = cmd_pre && pins_s3.a[AP_BIT];
    cmd_ref     = ck_rise && is_cmd(pins_s3, 1'b0, 1'b0, 1'b1);
    cmd_act     = ck_rise && is_cmd(pins_s3, 1'b0, 1'b1, 1'b1);
  end

  // ==========================================================
  // Bank state and mode register
  logic [3:0]  open_r, open_nxt;
  logic [12:0] mode_r, mode_nxt;
  logic        dll_en_r, dll_en_nxt;
  logic        rej_r, rej_nxt;

  always_comb
  begin
    banks_idle = (open_r == 4'h0);
    // Commands during a pending mode write still reach the decoder
    mrs_acc    = cmd_mrs && banks_idle;
    emrs_acc   = cmd_emrs && banks_idle;
    open_nxt   = open_r;
    if (cmd_act)
      open_nxt[pins_s3.ba] = 1'b1;
    if (cmd_pre_all)
      open_nxt = 4'h0;
    else if (cmd_pre)
      open_nxt[pins_s3.ba] = 1'b0;
    mode_nxt   = mrs_acc ? pins_s3.a : mode_r;
    dll_en_nxt = emrs_acc ? !pins_s3.a[EM_DLL_BIT] : dll_en_r;
    rej_nxt    = (cmd_mrs || cmd_emrs) && !banks_idle;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      open_r   <= 4'h0;
      mode_r   <= MODE_RST;
      dll_en_r <= 1'b0;
      rej_r    <= 1'b0;
    end
    else
    begin
      open_r   <= open_nxt;
      mode_r   <= mode_nxt;
      dll_en_r <= dll_en_nxt;
      rej_r    <= rej_nxt;
    end
  end

  // ==========================================================
  // Write completion and DLL lock timers, in CK cycles
  logic [1:0] busy_r, busy_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic       dll_rst_req;

  always_comb
  begin
    dll_rst_req = mrs_acc && pins_s3.a[DR_BIT];
    busy_nxt    = busy_r;
    if (mrs_acc || emrs_acc)
      busy_nxt = MRS_CK_CYC;
    else if (ck_rise && busy_r != 2'h0)
      busy_nxt = busy_r - 2'h1;
    lock_nxt = lock_r;
    if (dll_rst_req || (emrs_acc && !pins_s3.a[EM_DLL_BIT] && !dll_en_r))
      lock_nxt = DLL_LOCK_CYC;
    else if (ck_rise && lock_r != 8'h00)
      lock_nxt = lock_r - 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      busy_r <= 2'h0;
      lock_r <= DLL_LOCK_CYC;
    end
    else
    begin
      busy_r <= busy_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ==========================================================
  // Start-up sequence tracker
  ddrmr_init_t st_r, st_nxt;
  logic        got_rst_r, got_rst_nxt;
  logic        got_pre_r, got_pre_nxt;
  logic [1:0]  ref_r, ref_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    got_rst_nxt = got_rst_r;
    got_pre_nxt = got_pre_r;
    ref_nxt     = ref_r;
    case (st_r)
      ST_POWER:
        if (ck_rise && pins_s3.cke)
          st_nxt = ST_PRE1;
      ST_PRE1:
        if (cmd_pre_all)
          st_nxt = ST_EMRS;
      ST_EMRS:
        if (emrs_acc && !pins_s3.a[EM_DLL_BIT])
          st_nxt = ST_MID;
      ST_MID:
      begin
        // Either order of DLL reset and precharge is fine
        if (dll_rst_req)
          got_rst_nxt = 1'b1;
        if (cmd_pre_all)
          got_pre_nxt = 1'b1;
        if (cmd_ref && (got_pre_r || cmd_pre_all) && ref_r != MIN_REFRESH)
          ref_nxt = ref_r + 2'h1;
        if ((got_rst_r || dll_rst_req) && (got_pre_r || cmd_pre_all))
          st_nxt = ST_REFRESH;
      end
      ST_REFRESH:
      begin
        if (cmd_ref && ref_r != MIN_REFRESH)
          ref_nxt = ref_r + 2'h1;
        if (mrs_acc && !pins_s3.a[DR_BIT] && ref_r == MIN_REFRESH)
          st_nxt = ST_READY;
      end
      ST_READY:
        st_nxt = ST_READY;
      default:
        st_nxt = ST_POWER;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r      <= ST_POWER;
      got_rst_r <= 1'b0;
      got_pre_r <= 1'b0;
      ref_r     <= 2'h0;
    end
    else
    begin
      st_r      <= st_nxt;
      got_rst_r <= got_rst_nxt;
      got_pre_r <= got_pre_nxt;
      ref_r     <= ref_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign mode_o       = ddrmr_mode_t'(mode_r);
  assign dll_en_o     = dll_en_r;
  assign dll_locked_o = dll_en_r && lock_r == 8'h00;
  assign read_ok_o    = dll_en_r && lock_r == 8'h00 && st_r == ST_READY;
  assign mrs_busy_o   = busy_r != 2'h0;
  assign init_done_o  = st_r == ST_READY;
  assign cmd_reject_o = rej_r;

  ddrmr_burst u_burst (
    .mclk       (mclk),
    .rstn       (rstn),
    .burst_len  (mode_o.burst_len),
    .interleave (mode_o.interleave),
    .step       (burst_step),
    .start      (burst_start),
    .idx        (burst_idx),
    .col_o      (burst_col_o),
    .col_vld_o  (burst_col_vld_o)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_mrs_capture: assert property (mrs_acc |=> mode_r == $past(pins_s3.a))
    else $error("mode register not loaded from address");
  a_mrs_open_bank: assert property (cmd_mrs && !banks_idle |=> $stable(mode_r))
    else $error("mode register changed with bank open");
  a_mrs_cke_low: assert property (!pins_s3.cke |=> $stable(mode_r))
    else $error("mode register changed with CKE low");
  a_field_layout: assert property (mrs_acc |=> mode_o.burst_len == $past(pins_s3.a[2:0])
    && mode_o.interleave == $past(pins_s3.a[AM_BIT])
    && mode_o.cas_lat == $past(pins_s3.a[6:4]))
    else $error("mode field layout wrong");
  a_test_mode: assert property (mrs_acc && pins_s3.a[TM_BIT] |=> mode_o.test_mode)
    else $error("test mode bit not taken");
  a_dll_relock: assert property (
    dll_rst_req && dll_en_r |=> !dll_locked_o ##1 !dll_locked_o)
    else $error("DLL reset did not restart lock");
  a_mrs_busy: assert property (mrs_acc |=> mrs_busy_o[*3])
    else $error("mode write busy too short");
  a_reject_flag: assert property (
    cmd_emrs && open_r != 4'h0 |=> cmd_reject_o && $stable(dll_en_r))
    else $error("extended write with open bank not refused");
  a_ready_refresh: assert property (
    $rose(init_done_o) |-> $past(ref_r) == MIN_REFRESH)
    else $error("ready without two refreshes");

  c_init_done: cover property ($rose(init_done_o));
  c_dll_lock: cover property ($rose(dll_locked_o));
  c_reject: cover property (cmd_reject_o);
  c_rewrite: cover property (init_done_o && mrs_acc);

endmodule : ddrmr_top
`default_nettype wire

// [test/ddrmr_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ddrmr_ctrl_model
  import ddrmr_pkg::*;
(
  // Clocks
  input  wire logic   mclk,
  output logic        ck,
  // Command pins
  output ddrmr_pins_t pins
);
  // ====
  // CK runs free, phase unrelated to mclk
  initial
  begin
    ck = 1'b0;
    #3;
    forever #40 ck = ~ck;
  end

  initial pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};

  // ====
  // One command per call, driven after a CK fall
  task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
                       input logic [12:0] ad);
    // Spacing also covers the precharge period
    repeat (2) @(posedge ck);
    @(negedge ck);
    @(posedge mclk);
    pins <= '{k, c[3], c[2], c[1], c[0], b, ad};
    @(negedge ck);
    repeat (3) @(posedge mclk);
    // Released address inverted so a stale value cannot pass
    pins <= '{k, 1'b0, 1'b1, 1'b1, 1'b1, ~b, ~ad};
    #1;
  endtask : issue
endmodule : ddrmr_ctrl_model
`default_nettype wire

// [test/test_ddrmr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ddrmr_top
  import ddrmr_pkg::*;
();
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_NOP = 4'h7;

  logic        mclk;
  logic        rstn;
  logic        ck;
  ddrmr_pins_t pins;
  ddrmr_mode_t mode;
  logic        dll_en;
  logic        dll_locked;
  logic        read_ok;
  logic        mrs_busy;
  logic        init_done;
  logic        cmd_reject;
  logic        rej_seen;
  logic        burst_step;
  logic [2:0]  burst_start;
  logic [2:0]  burst_idx;
  logic [2:0]  burst_col;
  logic        burst_vld;
  int          err_count = 0;
  int          checks_done = 0;

  ddrmr_ctrl_model ctrl_u (.mclk(mclk), .ck(ck), .pins(pins));

  ddrmr_top dut_u (
    .mclk(mclk), .rstn(rstn), .ck(ck), .cke(pins.cke), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .ba(pins.ba),
    .a(pins.a), .mode_o(mode), .dll_en_o(dll_en), .dll_locked_o(dll_locked),
    .read_ok_o(read_ok), .mrs_busy_o(mrs_busy), .init_done_o(init_done),
    .cmd_reject_o(cmd_reject), .burst_step(burst_step), .burst_start(burst_start),
    .burst_idx(burst_idx), .burst_col_o(burst_col), .burst_col_vld_o(burst_vld)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Reject is a single-cycle pulse, so keep it
  always @(posedge mclk)
    if (cmd_reject === 1'b1)
      rej_seen <= 1'b1;

  // ====
  // Checking
  task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic burst(input logic [2:0] bl, input logic il, input logic [2:0] s,
                       input logic [2:0] i);
    logic [2:0] m;
    logic [2:0] e;
    m = (bl == BL_CODE_2) ? MASK_2 : (bl == BL_CODE_4) ? MASK_4 : MASK_8;
    e = il ? (s ^ i) : (s + i);
    @(posedge mclk);
    burst_step <= 1'b1;
    burst_start <= s;
    burst_idx <= i;
    @(posedge mclk);
    burst_step <= 1'b0;
    #1;
    check("burst_col", {9'h000, burst_vld, burst_col}, {9'h000, 1'b1, (e & m) | (s & ~m)});
  endtask : burst

  // ====
  // Tests
  initial
  begin
    rstn = 1'b0;
    rej_seen = 1'b0;
    burst_step = 1'b0;
    burst_start = 3'h0;
    burst_idx = 3'h0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    check("mode_rst", mode, MODE_RST);
    check("flags_rst", {8'h00, dll_en, dll_locked, read_ok, mrs_busy, init_done}, 13'h0000);
    repeat (20000) @(posedge mclk);
    ctrl_u.issue(1'b1, C_NOP, 2'h0, 13'h0000);
    ctrl_u.issue(1'b1, C_PRE, 2'h0, 13'h0400);
    ctrl_u.issue(1'b1, C_MRS, 2'h1, 13'h0000);
    check("dll_en", {11'h000, dll_en, dll_locked}, 13'h0002);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h0122);
    check("mode_dllrst", mode, 13'h0122);
    check("busy", {10'h000, mrs_busy, dll_locked, init_done}, 13'h0004);
    @(negedge ck);
    check("busy_one", {12'h000, mrs_busy}, 13'h0001);
    @(negedge ck);
    check("busy_done", {12'h000, mrs_busy}, 13'h0000);
    ctrl_u.issue(1'b1, C_PRE, 2'h3, 13'h0400);
    ctrl_u.issue(1'b1, C_REF, 2'h0, 13'h0000);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h0022);
    check("one_refresh", {12'h000, init_done}, 13'h0000);
    ctrl_u.issue(1'b1, C_REF, 2'h0, 13'h0000);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h0022);
    check("final_mode", mode, 13'h0022);
    check("final_flags", {10'h000, init_done, read_ok, dll_locked}, 13'h0004);
    repeat (200) @(posedge ck);
    #1;
    check("dll_lock", {11'h000, dll_locked, read_ok}, 13'h0003);
    ctrl_u.issue(1'b1, C_ACT, 2'h1, 13'h0010);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h0031);
    check("rej_mode", mode, 13'h0022);
    check("rej_flag", {12'h000, rej_seen}, 13'h0001);
    ctrl_u.issue(1'b1, C_MRS, 2'h1, 13'h0001);
    check("rej_dll", {12'h000, dll_en}, 13'h0001);
    ctrl_u.issue(1'b1, C_PRE, 2'h1, 13'h0000);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h1AB3);
    check("test_mode", mode, 13'h1AB3);
    ctrl_u.issue(1'b0, C_MRS, 2'h0, 13'h0032);
    check("cke_low", mode, 13'h1AB3);
    ctrl_u.issue(1'b1, C_NOP, 2'h0, 13'h0000);
    ctrl_u.issue(1'b1, C_MRS, 2'h0, 13'h0132);
    check("dll_relock", {12'h000, dll_locked}, 13'h0000);
    for (int c = 1; c < 4; c++)
      for (int il = 0; il < 2; il++)
      begin
        ctrl_u.issue(1'b1, C_MRS, 2'h0, {6'h00, 3'h2, il[0], c[2:0]});
        check("fields", {9'h000, mode.interleave, mode.burst_len}, {9'h000, il[0], c[2:0]});
        for (int s = 0; s < 8; s++)
          for (int i = 0; i < 8; i++)
            burst(c[2:0], il[0], s[2:0], i[2:0]);
      end
    complete_run();
  end

  // Hang guard, about 1.7 times the expected run
  initial
  begin
    #400us;
    err_count++;
    complete_run();
  end
endmodule : test_ddrmr_top
`default_nettype wire
